// *** rtl/fsst_defs.vh ***
// Constants for the float sqrt/subtract/store/truncate slice
// Functional notes
// - Square root rounded by current mode
// - Square root of minus zero gives minus zero
// - Square root of negative flags invalid
// - Square root raises only its listed exceptions
// - Subtract second from first, round, write
// - Subtract raises only its listed exceptions
// - Offset store: sign-extended offset plus base
// - Misaligned word store raises address error first
// - Steer word into lanes, endian address fix
// - Word store takes low 32 register bits
// - Word stores raise only listed exceptions
// - Indexed store: base plus index address
// - Long truncation rounds toward zero always
// - Truncation invalid on inf, NaN, range
// - Invalid traps if enabled, else max
// - Word truncation toward zero to 32 bits
`ifndef FSST_DEFS_VH
`define FSST_DEFS_VH
// Operation select codes
`define FSST_OP_SQRT   3'h0
`define FSST_OP_SUB    3'h1
`define FSST_OP_STOFS  3'h2
`define FSST_OP_STIDX  3'h3
`define FSST_OP_TRUNCL 3'h4
`define FSST_OP_TRUNCW 3'h5
// Format field values
`define FSST_FMT_S     5'h10
`define FSST_FMT_D     5'h11
// Exception codes
`define FSST_EXC_NONE  4'h0
`define FSST_EXC_CPU   4'h1
`define FSST_EXC_RI    4'h2
`define FSST_EXC_UNIMP 4'h3
`define FSST_EXC_INV   4'h4
`define FSST_EXC_ADEL  4'h5
`define FSST_EXC_TLBR  4'h6
`define FSST_EXC_TLBI  4'h7
`define FSST_EXC_TLBM  4'h8
// Rounding modes
`define FSST_RM_NEAR   2'h0
`define FSST_RM_ZERO   2'h1
`define FSST_RM_PINF   2'h2
`define FSST_RM_MINF   2'h3
// Flag bit positions
`define FSST_FL_INX    0
`define FSST_FL_UNF    1
`define FSST_FL_OVF    2
`define FSST_FL_INV    3
// Default values
`define FSST_QNAN_S    32'h7fbfffff
`define FSST_MAX_L     64'h7fffffffffffffff
`define FSST_MAX_W     64'h000000007fffffff
`define FSST_EXP_BIAS  10'h07f
`define FSST_ROOT_STEPS 26
`endif

// *** rtl/fsst_root.v ***
// Iterative restoring square root, one result bit per clock
`timescale 1ns/10ps
`include "fsst_defs.vh"
module fsst_root #(
   parameter ROOT_W = `FSST_ROOT_STEPS
)(
   input  wire                clock,    // Core clock
   input  wire                rst,      // Async reset
   input  wire                start,    // Begin a root
   input  wire [2*ROOT_W-1:0] radicand, // Value to root
   output reg                 done_ff,  // Root ready pulse
   output reg  [ROOT_W-1:0]   root_ff,  // Integer root
   output wire                sticky    // Remainder nonzero
);
   reg  [2*ROOT_W-1:0] rad_ff;  // Remaining radicand pairs
   reg  [ROOT_W+1:0]   rem_ff;  // Partial remainder
   reg  [7:0]          cnt_ff;  // Steps left
   wire [ROOT_W+3:0]   cur;     // Remainder with next pair
   wire [ROOT_W+3:0]   sub;     // Trial subtrahend
   assign cur    = {rem_ff, rad_ff[2*ROOT_W-1:2*ROOT_W-2]};
   assign sub    = {2'b00, root_ff, 2'b01};
   assign sticky = |rem_ff;
   ////////////////////////////////////////////////////////////////
   // One trial subtraction per step
   always @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         rad_ff  <= {2*ROOT_W{1'b0}};
         rem_ff  <= {(ROOT_W+2){1'b0}};
         root_ff <= {ROOT_W{1'b0}};
         cnt_ff  <= 8'h00;
         done_ff <= 1'b0;
      end
      else
      begin
         done_ff <= 1'b0;
         if (start)
         begin
            // Load and clear
            rad_ff  <= radicand;
            rem_ff  <= {(ROOT_W+2){1'b0}};
            root_ff <= {ROOT_W{1'b0}};
            cnt_ff  <= ROOT_W[7:0];
         end
         else if (cnt_ff != 8'h00)
         begin
            rad_ff <= {rad_ff[2*ROOT_W-3:0], 2'b00};
            if (cur >= sub)
            begin
               // Bit is one
               rem_ff  <= cur[ROOT_W+1:0] - sub[ROOT_W+1:0];
               root_ff <= {root_ff[ROOT_W-2:0], 1'b1};
            end
            else
            begin
               // Bit is zero
               rem_ff  <= cur[ROOT_W+1:0];
               root_ff <= {root_ff[ROOT_W-2:0], 1'b0};
            end
            cnt_ff  <= cnt_ff - 8'h01;
            done_ff <= (cnt_ff == 8'h01);
         end
      end
   end
endmodule

// *** rtl/fsst_top.v ***
// Float slice: square root, subtract, word stores, truncation
`timescale 1ns/10ps
`include "fsst_defs.vh"
module fsst_top #(
   parameter PA_W = 36
)(
   input  wire            clock,               // Core clock
   input  wire            rst,                 // Async reset
   input  wire            op_valid,            // Issue request
   input  wire [2:0]      op_sel,              // Operation
   input  wire [4:0]      op_fmt,              // Format field
   input  wire            cop_usable,          // Coprocessor on
   input  wire [63:0]     first_source_val,    // Register fs
   input  wire [63:0]     second_source_val,   // Register ft
   input  wire [63:0]     base_val,            // Base register
   input  wire [63:0]     index_val,           // Index register
   input  wire [15:0]     offset_val,          // Offset field
   input  wire [1:0]      round_mode,          // Rounding mode
   input  wire            invalid_enable,      // Invalid trap on
   input  wire            fgr_is_64,           // 64-bit registers
   input  wire            reverse_endian_flag, // Reverse endian
   input  wire            big_endian_flag,     // Big endian core
   input  wire            xlat_ack,            // Translation done
   input  wire [PA_W-1:0] xlat_paddr,          // Physical address
   input  wire [1:0]      xlat_exc,            // Translation fault
   output reg             busy_ff,             // Slice busy
   output reg             done_ff,             // Completion pulse
   output reg  [3:0]      exc_ff,              // Exception code
   output reg  [3:0]      flags_ff,            // Float flags
   output reg             dest_we_ff,          // Destination write
   output reg  [63:0]     dest_val_ff,         // Destination value
   output reg             xlat_req_ff,         // Translate request
   output reg  [63:0]     xlat_vaddr_ff,       // Virtual address
   output reg             mem_wr_ff,           // Memory write
   output reg  [PA_W-1:0] mem_paddr_ff,        // Write address
   output reg  [63:0]     mem_data_ff,         // Write data
   output reg  [7:0]      mem_be_ff            // Byte enables
);
   localparam ST_IDLE = 2'h0; // Waiting
   localparam ST_ROOT = 2'h1; // Root running
   localparam ST_XLAT = 2'h2; // Awaiting translation
   reg  [1:0]  st_ff;     // Control state
   reg  [31:0] word_ff;   // Store word
   reg  [2:0]  bsel_ff;   // Byte lane select
   reg  [9:0]  rexp_ff;   // Root exponent
   reg         rstart_ff; // Root start pulse
   reg  [51:0] rad_ff;    // Root radicand
   wire        rdone;     // Root finished
   wire [25:0] root;      // Root bits
   wire        rsticky;   // Root inexact tail
   ////////////////////////////////////////////////////////////////
   // Round and pack single: {ovf, inx, value}
   function [33:0] rpack;
      input       s;
      input [9:0] e;
      input [23:0] m;
      input       g;
      input       rs;
      input [1:0] rm;
      reg         inc;
      reg [24:0]  mr;
      reg [9:0]   ee;
      begin
         case (rm)
            `FSST_RM_NEAR: inc = g & (rs | m[0]);
            `FSST_RM_PINF: inc = ~s & (g | rs);
            `FSST_RM_MINF: inc = s & (g | rs);
            default:       inc = 1'b0;
         endcase
         mr = {1'b0, m} + {24'h000000, inc};
         ee = e + {9'h000, mr[24]};
         if (ee >= 10'h0ff)
         begin
            // Overflow: infinity or largest finite
            if (rm == `FSST_RM_ZERO || (rm == `FSST_RM_PINF && s) ||
                (rm == `FSST_RM_MINF && !s))
               rpack = {2'b11, s, 31'h7f7fffff};
            else
               rpack = {2'b11, s, 31'h7f800000};
         end
         else if (mr[24])
            rpack = {1'b0, g | rs, s, ee[7:0], mr[23:1]};
         else
            rpack = {1'b0, g | rs, s, ee[7:0], mr[22:0]};
      end
   endfunction
   ////////////////////////////////////////////////////////////////
   // Operand decode
   wire [31:0] a     = first_source_val[31:0];
   wire [31:0] b     = second_source_val[31:0];
   wire [7:0]  ea    = a[30:23];
   wire [7:0]  eb    = b[30:23];
   wire        a_nan = (&ea) & (|a[22:0]);
   wire        b_nan = (&eb) & (|b[22:0]);
   wire        a_inf = (&ea) & ~(|a[22:0]);
   wire        b_inf = (&eb) & ~(|b[22:0]);
   wire        a_den = ~(|ea) & (|a[22:0]);
   wire        b_den = ~(|eb) & (|b[22:0]);
   wire        a_zer = ~(|a[30:0]);
   wire        fmt_s = (op_fmt == `FSST_FMT_S);
   wire        fmt_d = (op_fmt == `FSST_FMT_D);
   ////////////////////////////////////////////////////////////////
   // Subtract datapath
   reg         sl, ss;    // Signs, larger/smaller
   reg  [7:0]  el, es, d; // Exponents and gap
   reg  [23:0] ml, ms;    // Significands
   reg  [26:0] al;        // Aligned smaller
   reg         stk;       // Alignment sticky
   reg  [27:0] sum;       // Raw sum
   reg  [26:0] nrm;       // Normalised sum
   reg  [9:0]  ne;        // Normalised exponent
   reg  [4:0]  pos;       // Leading one position
   reg  [33:0] spk;       // Packed result
   reg  [31:0] sub_res;   // Subtract value
   reg  [3:0]  sub_flg;   // Subtract flags
   reg         sub_unimp; // Needs software
   integer     i;
   always @*
   begin
      sl = a[31]; ss = ~b[31]; el = ea; es = eb;
      ml = {|ea, a[22:0]}; ms = {|eb, b[22:0]};
      if ({eb, |eb, b[22:0]} > {ea, |ea, a[22:0]})
      begin
         // Larger magnitude first
         sl = ~b[31]; ss = a[31]; el = eb; es = ea;
         ml = {|eb, b[22:0]}; ms = {|ea, a[22:0]};
      end
      d = el - es;
      if (d > 8'd26)
      begin
         al = 27'h0000000; stk = |ms;
      end
      else
      begin
         al  = {ms, 3'b000} >> d;
         stk = |({ms, 3'b000} & ~(27'h7ffffff << d));
      end
      if (sl == ss)
         sum = {1'b0, ml, 3'b000} + {1'b0, al[26:1], al[0] | stk};
      else
         sum = {1'b0, ml, 3'b000} - {1'b0, al[26:1], al[0] | stk};
      pos = 5'd0;
      for (i = 0; i < 27; i = i + 1)
         if (sum[i]) pos = i[4:0];
      if (sum[27])
      begin
         nrm = {sum[27:2], sum[1] | sum[0]};
         ne  = {2'b00, el} + 10'h001;
      end
      else
      begin
         nrm = sum[26:0] << (5'd26 - pos);
         ne  = {2'b00, el} - {5'h00, 5'd26 - pos};
      end
      spk = rpack(sl, ne, nrm[26:3], nrm[2], |nrm[1:0], round_mode);
      sub_res = spk[31:0]; sub_flg = 4'h0; sub_unimp = 1'b0;
      if (a_den | b_den)
         sub_unimp = 1'b1;
      else if (a_nan | b_nan)
      begin
         // Signalling NaN is invalid; any NaN operand gives the default quiet NaN
         sub_res = `FSST_QNAN_S;
         sub_flg[`FSST_FL_INV] = (a_nan & a[22]) | (b_nan & b[22]);
      end
      else if (a_inf & b_inf & (a[31] == b[31]))
      begin
         sub_res = `FSST_QNAN_S;
         sub_flg[`FSST_FL_INV] = 1'b1;
      end
      else if (a_inf | b_inf)
         sub_res = a_inf ? a : {~b[31], b[30:0]};
      else if (sum == 28'h0000000)
         sub_res = {(sl == ss) ? sl : (round_mode == `FSST_RM_MINF),
                    31'h0};
      else if ($signed(ne) < 10'sd1)
         sub_unimp = 1'b1;
      else
      begin
         sub_res = spk[31:0];
         sub_flg[`FSST_FL_INX] = spk[32];
         sub_flg[`FSST_FL_OVF] = spk[33];
      end
   end
   ////////////////////////////////////////////////////////////////
   // Truncation datapath, always toward zero
   wire [9:0]  ue   = {2'b00, ea} - `FSST_EXP_BIAS;
   wire [87:0] full = {64'h0, 1'b1, a[22:0]} << ue[5:0];
   wire [63:0] mag  = full[86:23];
   wire        tlong = (op_sel == `FSST_OP_TRUNCL);
   reg  [63:0] trn_res; // Truncated value
   reg         trn_inv; // Not representable
   reg         trn_inx; // Fraction dropped
   always @*
   begin
      trn_res = 64'h0; trn_inv = 1'b0; trn_inx = 1'b0;
      if (a_nan | a_inf)
         trn_inv = 1'b1;
      else if (ea < 8'd127)
         trn_inx = ~a_zer;
      else if (ue > 10'd63)
         trn_inv = 1'b1;
      else if (tlong ? (mag[63] & ~(a[31] & mag == 64'h1 << 63))
                     : ((|mag[63:31]) & ~(a[31] & mag == 64'h80000000)))
         trn_inv = 1'b1;
      else
      begin
         trn_inx = |full[22:0];
         trn_res = a[31] ? (64'h0 - mag) : mag;
         if (!tlong)
            trn_res = {32'h0, trn_res[31:0]};
      end
   end
   ////////////////////////////////////////////////////////////////
   // Square root operand screening and result packing
   wire [33:0] qpk = rpack(1'b0, rexp_ff, root[25:2], root[1],
                           root[0] | rsticky, round_mode);
   wire        sq_snan = a_nan & a[22];
   wire        sq_neg  = a[31] & ~a_zer & ~a_nan;
   ////////////////////////////////////////////////////////////////
   // Store address and lane steering
   wire        st_idx = (op_sel == `FSST_OP_STIDX);
   wire [63:0] vaddr  = base_val + (st_idx ? index_val :
                        {{48{offset_val[15]}}, offset_val});
   fsst_root #(.ROOT_W(`FSST_ROOT_STEPS)) u_root (
      .clock    (clock),
      .rst      (rst),
      .start    (rstart_ff),
      .radicand (rad_ff),
      .done_ff  (rdone),
      .root_ff  (root),
      .sticky   (rsticky)
   );
   ////////////////////////////////////////////////////////////////
   // Sequencing, completion and memory side
   always @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         st_ff <= ST_IDLE; busy_ff <= 1'b0; done_ff <= 1'b0;
         exc_ff <= `FSST_EXC_NONE; flags_ff <= 4'h0;
         dest_we_ff <= 1'b0; dest_val_ff <= 64'h0;
         xlat_req_ff <= 1'b0; xlat_vaddr_ff <= 64'h0;
         mem_wr_ff <= 1'b0; mem_paddr_ff <= {PA_W{1'b0}};
         mem_data_ff <= 64'h0; mem_be_ff <= 8'h00;
         word_ff <= 32'h0; bsel_ff <= 3'h0;
         rexp_ff <= 10'h000; rstart_ff <= 1'b0; rad_ff <= 52'h0;
      end
      else
      begin
         done_ff <= 1'b0; dest_we_ff <= 1'b0;
         mem_wr_ff <= 1'b0; rstart_ff <= 1'b0;
         case (st_ff)
            ST_IDLE:
            if (op_valid)
            begin
               // Default: complete now with no effects
               done_ff <= 1'b1; exc_ff <= `FSST_EXC_NONE;
               flags_ff <= 4'h0;
               if (!cop_usable)
                  exc_ff <= `FSST_EXC_CPU;
               else if (op_sel > `FSST_OP_TRUNCW ||
                        (op_sel != `FSST_OP_STOFS && !st_idx &&
                         !fmt_s && !fmt_d))
                  exc_ff <= `FSST_EXC_RI;
               else if (op_sel == `FSST_OP_STOFS || st_idx)
               begin
                  if (vaddr[1:0] != 2'b00)
                     exc_ff <= `FSST_EXC_ADEL;
                  else
                  begin
                     done_ff <= 1'b0; busy_ff <= 1'b1;
                     xlat_req_ff <= 1'b1; xlat_vaddr_ff <= vaddr;
                     word_ff <= st_idx ? first_source_val[31:0]
                                       : second_source_val[31:0];
                     bsel_ff <= vaddr[2:0] ^ {big_endian_flag, 2'b00};
                     st_ff <= ST_XLAT;
                  end
               end
               else if (fmt_d)
                  exc_ff <= `FSST_EXC_UNIMP;
               else if (op_sel == `FSST_OP_SUB)
               begin
                  if (sub_unimp)
                     exc_ff <= `FSST_EXC_UNIMP;
                  else if (sub_flg[`FSST_FL_INV] && invalid_enable)
                  begin
                     exc_ff <= `FSST_EXC_INV; flags_ff <= sub_flg;
                  end
                  else
                  begin
                     flags_ff <= sub_flg; dest_we_ff <= 1'b1;
                     dest_val_ff <= {32'h0, sub_res};
                  end
               end
               else if (op_sel == `FSST_OP_SQRT)
               begin
                  if (a_den)
                     exc_ff <= `FSST_EXC_UNIMP;
                  else if ((sq_snan | sq_neg) && invalid_enable)
                  begin
                     exc_ff <= `FSST_EXC_INV;
                     flags_ff <= 4'h1 << `FSST_FL_INV;
                  end
                  else if (sq_snan | sq_neg | a_nan)
                  begin
                     flags_ff <= {sq_snan | sq_neg, 3'b000};
                     dest_we_ff <= 1'b1;
                     dest_val_ff <= {32'h0, `FSST_QNAN_S};
                  end
                  else if (a_zer | a_inf)
                  begin
                     dest_we_ff <= 1'b1;
                     dest_val_ff <= {32'h0, a};
                  end
                  else
                  begin
                     // Start iterative root
                     done_ff <= 1'b0; busy_ff <= 1'b1;
                     rstart_ff <= 1'b1; st_ff <= ST_ROOT;
                     rexp_ff <= ({2'b00, ea} + `FSST_EXP_BIAS) >> 1;
                     rad_ff <= ea[0] ? {1'b0, 1'b1, a[22:0], 27'h0}
                                     : {1'b1, a[22:0], 28'h0};
                  end
               end
               else
               begin
                  // Truncation to long or word
                  flags_ff <= {trn_inv, 2'b00, trn_inx};
                  if (trn_inv && invalid_enable)
                     exc_ff <= `FSST_EXC_INV;
                  else
                  begin
                     dest_we_ff <= 1'b1;
                     dest_val_ff <= trn_inv ? (tlong ? `FSST_MAX_L
                                    : `FSST_MAX_W) : trn_res;
                  end
               end
            end
            ST_ROOT:
            if (rdone)
            begin
               // Root done: round and write
               done_ff <= 1'b1; busy_ff <= 1'b0; st_ff <= ST_IDLE;
               dest_we_ff <= 1'b1; dest_val_ff <= {32'h0, qpk[31:0]};
               flags_ff <= {3'b000, qpk[32]};
            end
            ST_XLAT:
            if (xlat_ack)
            begin
               done_ff <= 1'b1; busy_ff <= 1'b0; st_ff <= ST_IDLE;
               xlat_req_ff <= 1'b0;
               if (xlat_exc != 2'b00)
                  exc_ff <= `FSST_EXC_TLBR + {2'b00, xlat_exc} - 4'h1;
               else
               begin
                  mem_wr_ff <= 1'b1;
                  mem_paddr_ff <= {xlat_paddr[PA_W-1:3],
                     xlat_paddr[2:0] ^ {reverse_endian_flag, 2'b00}};
                  mem_data_ff <= bsel_ff[2] ? {word_ff, 32'h0}
                                            : {32'h0, word_ff};
                  mem_be_ff <= bsel_ff[2] ? 8'hf0 : 8'h0f;
               end
            end
            default:
               st_ff <= ST_IDLE;
         endcase
      end
   end
endmodule

// *** tb/fsst_xlat_model.sv ***
// Translation unit model answering the slice's store requests
`timescale 1ns/10ps
module fsst_xlat_model #(
   parameter PA_W = 36
)(
   input  wire            clock,  // Core clock
   input  wire            rst,    // Async reset
   input  wire            req,    // Translate request
   input  wire [63:0]     vaddr,  // Virtual address
   input  wire [3:0]      wait_n, // Cycles before answer
   input  wire [1:0]      fault,  // Fault to report
   output reg             ack,    // Answer pulse
   output reg  [PA_W-1:0] paddr,  // Physical address
   output reg  [1:0]      exc     // Fault code
);
   reg [3:0] cnt_ff; // Wait counter
   // Answer after wait_n cycles; garbage on the lines otherwise
   always @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         ack <= 1'b0;
         cnt_ff <= 4'h0;
         paddr <= {PA_W{1'b0}};
         exc <= 2'h0;
      end
      else
      begin
         ack <= 1'b0;
         paddr <= ~paddr;
         exc <= ~exc;
         if (req && !ack && cnt_ff == wait_n)
         begin
            ack <= 1'b1;
            paddr <= {4'h1, vaddr[31:0]};
            exc <= fault;
            cnt_ff <= 4'h0;
         end
         else if (req && !ack)
            cnt_ff <= cnt_ff + 4'h1;
      end
   end
endmodule

// *** tb/fsst_assertions.sv ***
// Port checker for the float slice
`timescale 1ns/10ps
module fsst_assertions (
   input logic       clock,       // Core clock
   input logic       rst,         // Async reset
   input logic       op_valid,    // Issue request
   input logic [2:0] op_sel,      // Operation
   input logic       cop_usable,  // Coprocessor on
   input logic       xlat_ack,    // Translation done
   input logic [1:0] xlat_exc,    // Translation fault
   input logic       busy_ff,     // Slice busy
   input logic       done_ff,     // Completion pulse
   input logic [3:0] exc_ff,      // Exception code
   input logic       dest_we_ff,  // Destination write
   input logic       xlat_req_ff, // Translate request
   input logic       mem_wr_ff,   // Memory write
   input logic [7:0] mem_be_ff    // Byte enables
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   wire iss = op_valid && !busy_ff && !done_ff; // Request taken
   wire ok = iss && cop_usable;                 // Taken, enabled
   sequence s_sq;
      ok && op_sel == 3'h0 ##1 busy_ff;
   endsequence
   property p_sq;
      s_sq |-> busy_ff [*8] ##21 done_ff && dest_we_ff;
   endproperty
   property p_cpu;
      iss && !cop_usable |=> done_ff && exc_ff == 4'h1 && !dest_we_ff
         && !xlat_req_ff && !mem_wr_ff;
   endproperty
   property p_one;
      ok && (op_sel == 3'h1 || op_sel[2:1] == 2'b10) |=> done_ff;
   endproperty
   property p_rsv;
      ok && op_sel[2:1] == 2'b11 |=> done_ff && exc_ff == 4'h2;
   endproperty
   property p_st;
      ok && op_sel[2:1] == 2'b01 |=> (done_ff && exc_ff == 4'h5
         && !xlat_req_ff) || (busy_ff && xlat_req_ff && !done_ff);
   endproperty
   property p_ack;
      xlat_req_ff && xlat_ack |=> done_ff && !xlat_req_ff
         && mem_wr_ff == ($past(xlat_exc) == 2'h0)
         && exc_ff == ($past(xlat_exc) == 2'h0 ? 4'h0
            : 4'h5 + {2'h0, $past(xlat_exc)});
   endproperty
   property p_hold;
      xlat_req_ff && !xlat_ack |=> xlat_req_ff && !done_ff;
   endproperty
   property p_be;
      mem_wr_ff |-> mem_be_ff == 8'h0f || mem_be_ff == 8'hf0;
   endproperty
   property p_we;
      dest_we_ff |-> done_ff && exc_ff == 4'h0 && !mem_wr_ff;
   endproperty
   a_sq: assert property (p_sq) else $error("root timing");
   a_cpu: assert property (p_cpu) else $error("unusable");
   a_one: assert property (p_one) else $error("late done");
   a_rsv: assert property (p_rsv) else $error("reserved");
   a_st: assert property (p_st) else $error("store start");
   a_ack: assert property (p_ack) else $error("store end");
   a_hold: assert property (p_hold) else $error("req drop");
   a_be: assert property (p_be) else $error("lanes");
   a_we: assert property (p_we) else $error("bad write");
endmodule
bind fsst_top fsst_assertions fsst_assertions_i (.clock, .rst,
   .op_valid, .op_sel, .cop_usable, .xlat_ack, .xlat_exc, .busy_ff,
   .done_ff, .exc_ff, .dest_we_ff, .xlat_req_ff, .mem_wr_ff, .mem_be_ff);

// *** tb/fsst_top_tb.sv ***
// Self-checking bench for the float slice
`timescale 1ns/10ps
`include "fsst_defs.vh"
module fsst_top_tb;
   reg clock = 1'b0, rst = 1'b1, op_valid = 1'b0, cop_usable = 1'b1;
   reg invalid_enable = 1'b0, fgr_is_64 = 1'b1, we, wr;
   reg reverse_endian_flag = 1'b0, big_endian_flag = 1'b0;
   reg [2:0] op_sel = 3'h0;            // Operation
   reg [4:0] op_fmt = `FSST_FMT_S;     // Format field
   reg [63:0] first_source_val = 64'h0, second_source_val = 64'h0;
   reg [63:0] base_val = 64'h0, index_val = 64'h0, va; // Addresses
   reg [15:0] offset_val = 16'h0;      // Offset field
   reg [1:0] round_mode = 2'h0, fault = 2'h0; // Mode, forced fault
   reg [3:0] wait_n = 4'h2;            // Translation delay
   wire busy_ff, done_ff, dest_we_ff, xlat_req_ff, mem_wr_ff, xlat_ack;
   wire [3:0] exc_ff, flags_ff;        // Status
   wire [63:0] dest_val_ff, xlat_vaddr_ff, mem_data_ff; // Data
   wire [35:0] mem_paddr_ff, xlat_paddr; // Physical addresses
   wire [7:0] mem_be_ff;               // Byte enables
   wire [1:0] xlat_exc;                // Translation fault
   integer mismatches = 0, n_checks = 0, cyc = 0, k;
   fsst_top fsst_top_i (.*);
   fsst_xlat_model fsst_xlat_model_i (.clock(clock), .rst(rst),
      .req(xlat_req_ff), .vaddr(xlat_vaddr_ff), .wait_n(wait_n),
      .fault(fault), .ack(xlat_ack), .paddr(xlat_paddr), .exc(xlat_exc));
   always #4 clock = ~clock;
   // Cut a hang short
   always @(posedge clock)
   begin
      cyc = cyc + 1;
      if (cyc == 4000)
      begin
         mismatches = mismatches + 1;
         end_sim;
      end
   end
   task end_sim;
      if (mismatches == 0 && n_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task chk(input string nm, input [63:0] e, input [63:0] g);
      n_checks = n_checks + 1;
      if (e !== g)
      begin
         mismatches = mismatches + 1;
         $display("mismatch %s exp %h got %h", nm, e, g);
      end
   endtask
   // Issue one operation and wait for its completion pulse
   task run(input [2:0] s, input [63:0] a, input [63:0] b);
      op_sel = s;
      first_source_val = a;
      second_source_val = b;
      op_valid = 1'b1;
      @(negedge clock) op_valid = 1'b0;
      for (k = 0; k < 60 && done_ff !== 1'b1; k = k + 1)
         @(negedge clock);
      we = dest_we_ff;
      wr = mem_wr_ff;
      @(negedge clock);
   endtask
   task res(input [63:0] v, input [3:0] x, input w);
      chk("exc", {60'h0, x}, {60'h0, exc_ff});
      chk("we", {63'h0, w}, {63'h0, we});
      if (w)
         chk("dest", v, dest_val_ff);
   endtask
   task t_arith;
      run(3'h0, 64'h40800000, 0); res(64'h40000000, 0, 1);
      run(3'h0, 64'h80000000, 0); res(64'h80000000, 0, 1);
      invalid_enable = 1'b1;
      run(3'h0, 64'hc0800000, 0); res(0, 4'h4, 0);
      run(3'h1, 64'h40400000, 64'h3f800000); res(64'h40000000, 0, 1);
      round_mode = 2'h1;
      run(3'h1, 64'h3f800000, 64'h30800000); res(64'h3f7fffff, 0, 1);
      chk("inexact", 1, {63'h0, flags_ff[0]});
      round_mode = 2'h3;
      run(3'h4, 64'hc0200000, 0); res(64'hfffffffffffffffe, 0, 1);
      run(3'h5, 64'h40200000, 0); res(64'h2, 0, 1);
      run(3'h4, 64'h5f000000, 0); res(0, 4'h4, 0);
      invalid_enable = 1'b0;
      run(3'h4, 64'h7f800000, 0); res(`FSST_MAX_L, 0, 1);
      chk("invalid", 1, {63'h0, flags_ff[3]});
   endtask
   // Offset stores under every endian setting, then indexed
   task t_store;
      base_val = 64'h1000;
      offset_val = 16'hfffc;
      va = 64'hffc;
      for (int i = 0; i < 4; i++)
      begin
         {big_endian_flag, reverse_endian_flag} = i[1:0];
         fgr_is_64 = i[0];
         run(3'h2, 0, 64'hdeadbeef12345678);
         chk("wr", 1, {63'h0, wr});
         chk("vaddr", va, xlat_vaddr_ff);
         chk("data", (va[2] ^ i[1]) ? 64'h1234567800000000 : 64'h12345678, mem_data_ff);
         chk("be", (va[2] ^ i[1]) ? 8'hf0 : 8'h0f, {56'h0, mem_be_ff});
         chk("paddr", {28'h1, va[31:3], va[2] ^ i[0], 2'h0}, {28'h0, mem_paddr_ff});
      end
      {big_endian_flag, reverse_endian_flag} = 2'h0;
      base_val = 64'h2000;
      index_val = 64'h8;
      run(3'h3, 64'h55aa55aacafef00d, 0);
      chk("data", 64'hcafef00d, mem_data_ff);
      chk("vaddr", 64'h2008, xlat_vaddr_ff);
      offset_val = 16'h2;
      index_val = 64'h1;
      run(3'h2, 0, 0); res(0, 4'h5, 0);
      run(3'h3, 0, 0); res(0, 4'h5, 0);
      offset_val = 16'h0;
      wait_n = 4'h0;
      for (int f = 1; f < 4; f++)
      begin
         fault = f[1:0];
         run(3'h2, 0, 0); res(0, 4'h5 + f[3:0], 0);
         chk("wr", 0, {63'h0, wr});
      end
      fault = 2'h0;
   endtask
   task t_refuse;
      cop_usable = 1'b0;
      run(3'h1, 64'h3f800000, 0); res(0, 4'h1, 0);
      run(3'h2, 0, 0); res(0, 4'h1, 0);
      cop_usable = 1'b1;
      run(3'h6, 0, 0); res(0, 4'h2, 0);
      op_fmt = `FSST_FMT_D;
      run(3'h1, 0, 0); res(0, 4'h3, 0);
      op_fmt = 5'h00;
      run(3'h0, 0, 0); res(0, 4'h2, 0);
   endtask
   initial
   begin
      repeat (20) @(negedge clock);
      rst = 1'b0;
      t_arith;
      t_store;
      t_refuse;
      end_sim;
   end
endmodule
